// File: src/irf_top.sv
// Interrupt request flag registers: external, DMA/infrared and converter/serial.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "irf_cfg.svh"
module irf_top
    import irf_pkg::*;
(
    input wire logic mclk, // Clock, 10 MHz.
    input wire logic sys_rst, // Synchronous reset.
    input wire logic [4:0] reg_addr, // Byte address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [7:0] reg_rdata, // Read data, next cycle.
    input wire logic [5:0] ext_pin, // External pin requests.
    input wire logic [15:0] port_pin, // Port pin requests.
    input wire logic [3:0] dma_end_req, // DMA channel ends.
    input wire logic [3:0] ir_req, // Infrared tx,brk,rx,err.
    input wire logic adc_done_req, // Converter done.
    input wire logic [3:0] fifo_req, // Serial tx,brk,rx,err.
    input wire logic standby, // Standby, holds flags.
    output logic irq_out // Level interrupt.
);

    ////////////////////////////////////////////////////////////////
    // Address decode.
    ////////////////////////////////////////////////////////////////

    // Decode is shared by the write and read paths.
    function automatic irf_sel_t dec(input logic [4:0] a);
        irf_sel_t s;
        s = IRF_SEL_NONE;
        case (a)
            `IRF_OFS_EXT: s = IRF_SEL_EXT;
            `IRF_OFS_DMA: s = IRF_SEL_DMA;
            `IRF_OFS_CNV: s = IRF_SEL_CNV;
            `IRF_OFS_MODE: s = IRF_SEL_MODE;
            `IRF_OFS_STAT: s = IRF_SEL_STAT;
            `IRF_OFS_MASK: s = IRF_SEL_MASK;
            default: s = IRF_SEL_NONE;
        endcase
        return s;
    endfunction

    // Rising bits of a flag byte, used for the event status.
    function automatic logic rose(input irf_byte_t nxt, input irf_byte_t cur);
        return |(nxt & ~cur);
    endfunction

    irf_sel_t wsel;
    irf_sel_t rsel;

    // The strobe gates the decode so an idle bus selects nothing.
    assign wsel = reg_wr ? dec(reg_addr) : IRF_SEL_NONE;
    assign rsel = reg_rd ? dec(reg_addr) : IRF_SEL_NONE;

    ////////////////////////////////////////////////////////////////
    // Helper modules.
    ////////////////////////////////////////////////////////////////

    irf_wr_if wbus();

    // Only the external register and the own control registers take writes.
    assign wbus.wr_ext = (wsel == IRF_SEL_EXT);
    assign wbus.wr_mode = (wsel == IRF_SEL_MODE);
    assign wbus.wr_stat = (wsel == IRF_SEL_STAT);
    assign wbus.wr_mask = (wsel == IRF_SEL_MASK);
    assign wbus.wdata = reg_wdata;
    assign wbus.hold = standby;

    irf_ext_flags u_ext (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ext_pin(ext_pin),
        .bus(wbus)
    );

    irf_irq_status u_irq (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .bus(wbus)
    );

    assign irq_out = wbus.irq;

    ////////////////////////////////////////////////////////////////
    // Port group and peripheral flags.
    ////////////////////////////////////////////////////////////////

    logic [1:0] grp_r;
    logic [1:0] grp_nxt;
    irf_byte_t dma_r;
    irf_byte_t dma_nxt;
    irf_byte_t cnv_r;
    irf_byte_t cnv_nxt;
    irf_byte_t ext_view;
    irf_byte_t ext_view_r;

    // Flags follow their sources; standby freezes them so nothing is lost.
    always_comb begin
        grp_nxt = grp_r;
        dma_nxt = dma_r;
        cnv_nxt = cnv_r;
        if (!standby) begin
            grp_nxt[1] = |port_pin[7:0];
            grp_nxt[0] = |port_pin[15:8];
            dma_nxt = {ir_req, dma_end_req};
            cnv_nxt = {3'h0, adc_done_req, fifo_req};
        end
    end

    // Plain registering; software writes never reach these flags.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            grp_r <= 2'h0;
            dma_r <= `IRF_RST_BYTE;
            cnv_r <= `IRF_RST_BYTE;
        end else begin
            grp_r <= grp_nxt;
            dma_r <= dma_nxt;
            cnv_r <= cnv_nxt;
        end
    end

    // External register view: group bits above the pin flags.
    always_comb begin
        ext_view = {2'h0, wbus.ext_flags};
        ext_view[`IRF_BIT_LOWER] = grp_r[1];
        ext_view[`IRF_BIT_UPPER] = grp_r[0];
    end

    ////////////////////////////////////////////////////////////////
    // Event detection for the sticky status.
    ////////////////////////////////////////////////////////////////

    // A previous copy of the external view shows new requests.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ext_view_r <= `IRF_RST_BYTE;
        end else begin
            ext_view_r <= ext_view;
        end
    end

    // Bit 0 external, bit 1 DMA/infrared, bit 2 converter/serial.
    assign wbus.events = {rose(cnv_nxt, cnv_r), rose(dma_nxt, dma_r), rose(ext_view, ext_view_r)};

    ////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////

    irf_byte_t rdata_r;
    irf_byte_t rdata_nxt;

    // Read data stand only in the cycle after the strobe; otherwise zero.
    always_comb begin
        rdata_nxt = 8'h00;
        case (rsel)
            IRF_SEL_EXT: rdata_nxt = ext_view;
            IRF_SEL_DMA: rdata_nxt = dma_r;
            IRF_SEL_CNV: rdata_nxt = cnv_r & `IRF_CNV_USED;
            IRF_SEL_MODE: rdata_nxt = {2'h0, wbus.mode};
            IRF_SEL_STAT: rdata_nxt = {5'h00, wbus.stat};
            IRF_SEL_MASK: rdata_nxt = {5'h00, wbus.mask};
            IRF_SEL_NONE: rdata_nxt = 8'h00;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Registering the read data gives the fixed one-cycle latency.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r <= `IRF_RST_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence rd_of_dma;
        reg_rd && reg_addr == `IRF_OFS_DMA;
    endsequence

    sequence rd_of_cnv;
        reg_rd && reg_addr == `IRF_OFS_CNV;
    endsequence

    sequence rd_of_ext;
        reg_rd && reg_addr == `IRF_OFS_EXT;
    endsequence

    upper_group_a: assert property (!standby |=> ext_view[6] == ($past(port_pin[15:8]) != 8'h00))
        else $error("Upper port group flag wrong.");
    lower_group_a: assert property (!standby |=> ext_view[7] == ($past(port_pin[7:0]) != 8'h00))
        else $error("Lower port group flag wrong.");
    ir_map_a: assert property (!standby |=> dma_r[7:4] == $past(ir_req))
        else $error("Infrared flags mismapped.");
    dma_map_a: assert property (!standby |=> dma_r[3:0] == $past(dma_end_req))
        else $error("DMA end flags mismapped.");
    adc_flag_a: assert property (!standby && adc_done_req |=> cnv_r[4])
        else $error("Converter done flag missing.");
    fifo_map_a: assert property (!standby |=> cnv_r[3:0] == $past(fifo_req))
        else $error("Serial flags mismapped.");
    cnv_rsvd_a: assert property (rd_of_cnv |=> reg_rdata[7:5] == 3'h0)
        else $error("Reserved bits read nonzero.");
    read_only_a: assert property (rd_of_dma |=> reg_rdata == $past(dma_r))
        else $error("DMA register read wrong.");
    standby_hold_a: assert property (standby |=> $stable(dma_r) && $stable(cnv_r) && $stable(grp_r))
        else $error("Standby changed the flags.");
    reset_zero_a: assert property (@(posedge mclk) $past(sys_rst) |-> dma_r == 8'h00 && cnv_r == 8'h00)
        else $error("Flags not zero after reset.");
    idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data outside the read slot.");
    ext_read_a: assert property (rd_of_ext |=> reg_rdata == $past(ext_view))
        else $error("External register read wrong.");
    // A new DMA/infrared flag must reach the sticky status on the next edge, or the event is lost.
    dma_event_a: assert property (rose(dma_nxt, dma_r) |=> wbus.stat[1])
        else $error("DMA/infrared event missing from status.");
endmodule
`default_nettype wire

// File: pkg/irf_cfg.svh
// Offsets, field positions, reset values and rule summary for the request flag block.
// Function
// - Bit 6 shows any upper port pin request.
// - Bit 7 shows any lower port pin request.
// - Bits 5..0 show external pin requests.
// - Edge mode latches until software clears flag.
// - DMA/infrared register is read-only, eight bits.
// - Reset clears flags; standby keeps them.
// - Bits 7..4 are infrared transmit, break, receive, error.
// - Bits 3..0 are DMA channel end requests.
// - Converter/serial register is read-only, eight bits.
// - Reserved bits 7..5 always read zero.
// - Bit 4 shows converter done request.
// - Bits 3..0 are serial transmit, break, receive, error.
// - Flag reads one while request generated.
`ifndef IRF_CFG_SVH
`define IRF_CFG_SVH
`define IRF_OFS_EXT 5'h00
`define IRF_OFS_DMA 5'h04
`define IRF_OFS_CNV 5'h08
`define IRF_OFS_MODE 5'h0C
`define IRF_OFS_STAT 5'h10
`define IRF_OFS_MASK 5'h14
`define IRF_BIT_UPPER 6
`define IRF_BIT_LOWER 7
`define IRF_RST_BYTE 8'h00
`define IRF_RST_EXT 6'h00
`define IRF_RST_EV 3'h0
`define IRF_CNV_USED 8'h1F
`endif

// File: pkg/irf_pkg.sv
// Types shared by the request flag block.
package irf_pkg;
    typedef logic [7:0] irf_byte_t;
    typedef enum {
        IRF_SEL_EXT,
        IRF_SEL_DMA,
        IRF_SEL_CNV,
        IRF_SEL_MODE,
        IRF_SEL_STAT,
        IRF_SEL_MASK,
        IRF_SEL_NONE
    } irf_sel_t;
endpackage

// File: pkg/irf_wr_if.sv
// Internal write and status carrier between the flag block and its helpers.
`timescale 1ns/1ns
`default_nettype none
interface irf_wr_if;
    import irf_pkg::*;
    logic wr_ext;
    logic wr_mode;
    logic wr_stat;
    logic wr_mask;
    logic hold;
    irf_byte_t wdata;
    logic [5:0] ext_flags;
    logic [5:0] mode;
    logic [2:0] events;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
    modport ctl(output wr_ext, wr_mode, wr_stat, wr_mask, hold, wdata, events,
                input ext_flags, mode, stat, mask, irq);
    modport ext(input wr_ext, wr_mode, hold, wdata, output ext_flags, mode);
    modport irq_side(input wr_stat, wr_mask, wdata, events, output stat, mask, irq);
endinterface
`default_nettype wire

// File: src/irf_ext_flags.sv
// External pin request flags with per-pin edge or level detection.
`timescale 1ns/1ns
`default_nettype none
`include "irf_cfg.svh"
module irf_ext_flags
    import irf_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic sys_rst, // Synchronous reset.
    input wire logic [5:0] ext_pin, // Sampled pin requests.
    irf_wr_if.ext bus // Writes and flag readback.
);
    logic [5:0] flag_r, flag_nxt;
    logic [5:0] prev_r, prev_nxt;
    logic [5:0] mode_r, mode_nxt;
    logic [5:0] rise, clr;

    // A rising request sets an edge flag; a set in the clearing cycle wins.
    always_comb begin
        rise = bus.hold ? 6'h00 : (ext_pin & ~prev_r);
        clr = bus.wr_ext ? ~bus.wdata[5:0] : 6'h00;
        prev_nxt = bus.hold ? prev_r : ext_pin;
        mode_nxt = bus.wr_mode ? bus.wdata[5:0] : mode_r;
        flag_nxt = (mode_r & (rise | (flag_r & ~clr)))
                 | (~mode_r & (bus.hold ? flag_r : ext_pin));
    end

    // Plain registering of the flag state.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_r <= `IRF_RST_EXT;
            prev_r <= `IRF_RST_EXT;
            mode_r <= `IRF_RST_EXT;
        end else begin
            flag_r <= flag_nxt;
            prev_r <= prev_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign bus.ext_flags = flag_r;
    assign bus.mode = mode_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    edge_hold_a: assert property (mode_r[0] && flag_r[0] && !(bus.wr_ext && !bus.wdata[0]) ##1 mode_r[0]
        |-> flag_r[0]) else $error("Edge flag dropped without a clear.");
    level_follow_a: assert property (!mode_r[1] && !bus.hold |=> flag_r[1] == $past(ext_pin[1]))
        else $error("Level flag does not follow its pin.");
    write_one_a: assert property (bus.wr_ext && bus.wdata[2] && mode_r[2] && flag_r[2] |=> flag_r[2])
        else $error("Writing one changed an edge flag.");
endmodule
`default_nettype wire

// File: src/irf_irq_status.sv
// Sticky event status, mask and the level interrupt output.
`timescale 1ns/1ns
`default_nettype none
`include "irf_cfg.svh"
module irf_irq_status
    import irf_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic sys_rst, // Synchronous reset.
    irf_wr_if.irq_side bus // Events, writes and readback.
);
    logic [2:0] stat_r, stat_nxt;
    logic [2:0] mask_r, mask_nxt;

    // Write one clears; an event in the same cycle keeps its bit set.
    always_comb begin
        stat_nxt = bus.events | (stat_r & ~(bus.wr_stat ? bus.wdata[2:0] : 3'h0));
        mask_nxt = bus.wr_mask ? bus.wdata[2:0] : mask_r;
    end

    // Plain registering of status and mask.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stat_r <= `IRF_RST_EV;
            mask_r <= `IRF_RST_EV;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign bus.stat = stat_r;
    assign bus.mask = mask_r;
    assign bus.irq = |(stat_r & mask_r);
endmodule
`default_nettype wire

// File: verif/irf_src_model.sv
// Far-side model of the pins and peripheral sources that raise requests.
`timescale 1ns/1ns
`default_nettype none
module irf_src_model (
    input wire logic mclk, // Clock.
    input wire logic [34:0] want, // Source levels asked by the bench.
    output logic [5:0] ext_pin, // External pins.
    output logic [15:0] port_pin, // Port pins.
    output logic [3:0] dma_end_req, // DMA channel ends.
    output logic [3:0] ir_req, // Infrared sources.
    output logic adc_done_req, // Converter done.
    output logic [3:0] fifo_req // Serial sources.
);
    // Sources move only after an edge and hold a request until it is withdrawn.
    always @(posedge mclk) begin
        {ext_pin, port_pin, dma_end_req, ir_req, adc_done_req, fifo_req} <= want;
    end
endmodule
`default_nettype wire

// File: verif/irf_top_tb_top.sv
// Self-checking bench for the request flag registers.
`timescale 1ns/1ns
`default_nettype none
`include "irf_cfg.svh"
module irf_top_tb_top;
    import irf_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic standby = 1'b0;
    logic [5:0] w_ext = 6'h00;
    logic [15:0] w_port = 16'h0000;
    logic [3:0] w_dma = 4'h0;
    logic [3:0] w_ir = 4'h0;
    logic w_adc = 1'b0;
    logic [3:0] w_fifo = 4'h0;
    wire logic [7:0] reg_rdata;
    wire logic irq_out;
    wire logic [5:0] ext_pin;
    wire logic [15:0] port_pin;
    wire logic [3:0] dma_end_req;
    wire logic [3:0] ir_req;
    wire logic adc_done_req;
    wire logic [3:0] fifo_req;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    // Far side and the block itself.
    irf_src_model src (.mclk(mclk), .want({w_ext, w_port, w_dma, w_ir, w_adc, w_fifo}),
        .ext_pin(ext_pin), .port_pin(port_pin), .dma_end_req(dma_end_req), .ir_req(ir_req),
        .adc_done_req(adc_done_req), .fifo_req(fifo_req));
    irf_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
        .port_pin(port_pin), .dma_end_req(dma_end_req), .ir_req(ir_req),
        .adc_done_req(adc_done_req), .fifo_req(fifo_req), .standby(standby), .irq_out(irq_out));
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling well above the few hundred cycles the tests need.
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared bus cycles and comparison.
    task automatic close_out;
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rdc(input string name, input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask
    // Source moves one edge late in the model and one more in the flags.
    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        logic [4:0] ofs[7] = '{`IRF_OFS_EXT, `IRF_OFS_DMA, `IRF_OFS_CNV, `IRF_OFS_MODE,
            `IRF_OFS_STAT, `IRF_OFS_MASK, 5'h1C};
        wr(5'h1C, 8'hFF);
        foreach (ofs[i]) rdc("reset", ofs[i], 8'h00);
        @(posedge mclk);
        #1;
        chk("rdata idle", 8'h00, reg_rdata);
    endtask
    task automatic t_periph;
        for (int i = 0; i < 4; i++) begin
            w_dma <= 4'h1 << i;
            w_ir <= 4'h1 << i;
            w_fifo <= 4'h1 << i;
            settle();
            rdc("dma ir", `IRF_OFS_DMA, (8'h10 << i) | (8'h01 << i));
            rdc("serial", `IRF_OFS_CNV, 8'h01 << i);
        end
        {w_dma, w_ir, w_fifo, w_adc} <= 13'h1FFF;
        settle();
        wr(`IRF_OFS_DMA, 8'h00);
        wr(`IRF_OFS_CNV, 8'h00);
        rdc("dma ro", `IRF_OFS_DMA, 8'hFF);
        rdc("cnv ro", `IRF_OFS_CNV, 8'h1F);
        {w_dma, w_ir, w_fifo, w_adc} <= 13'h0000;
        settle();
        rdc("cnv off", `IRF_OFS_CNV, 8'h00);
    endtask
    task automatic t_ports;
        for (int i = 0; i < 16; i++) begin
            w_port <= 16'h0001 << i;
            settle();
            rdc("port group", `IRF_OFS_EXT, (i < 8) ? 8'h80 : 8'h40);
        end
        w_port <= 16'h0000;
        settle();
        rdc("port idle", `IRF_OFS_EXT, 8'h00);
    endtask
    task automatic t_level_edge;
        w_ext <= 6'h2A;
        settle();
        wr(`IRF_OFS_EXT, 8'h00);
        rdc("level", `IRF_OFS_EXT, 8'h2A);
        w_ext <= 6'h00;
        settle();
        rdc("level off", `IRF_OFS_EXT, 8'h00);
        wr(`IRF_OFS_MODE, 8'h3F);
        rdc("mode", `IRF_OFS_MODE, 8'h3F);
        w_ext <= 6'h3F;
        settle();
        w_ext <= 6'h00;
        settle();
        rdc("edge held", `IRF_OFS_EXT, 8'h3F);
        wr(`IRF_OFS_EXT, 8'hFE);
        rdc("edge clear", `IRF_OFS_EXT, 8'h3E);
        wr(`IRF_OFS_EXT, 8'hDF);
        rdc("edge clear5", `IRF_OFS_EXT, 8'h1E);
        // A reset in mid-run must drop latched flags and the mode.
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc("rst ext", `IRF_OFS_EXT, 8'h00);
        rdc("rst mode", `IRF_OFS_MODE, 8'h00);
    endtask
    task automatic t_irq;
        wr(`IRF_OFS_STAT, 8'h07);
        w_dma <= 4'h4;
        settle();
        w_dma <= 4'h0;
        settle();
        rdc("status", `IRF_OFS_STAT, 8'h02);
        chk("irq unmasked off", 8'h00, {7'h00, irq_out});
        wr(`IRF_OFS_MASK, 8'h01);
        #1;
        chk("irq other mask", 8'h00, {7'h00, irq_out});
        wr(`IRF_OFS_MASK, 8'h02);
        #1;
        chk("irq on", 8'h01, {7'h00, irq_out});
        wr(`IRF_OFS_STAT, 8'h02);
        #1;
        chk("irq cleared", 8'h00, {7'h00, irq_out});
        rdc("status clr", `IRF_OFS_STAT, 8'h00);
        w_ext <= 6'h01;
        w_adc <= 1'b1;
        settle();
        w_ext <= 6'h00;
        w_adc <= 1'b0;
        settle();
        rdc("status ext cnv", `IRF_OFS_STAT, 8'h05);
        wr(`IRF_OFS_STAT, 8'h05);
        rdc("status clr2", `IRF_OFS_STAT, 8'h00);
    endtask
    task automatic t_standby;
        standby <= 1'b1;
        w_fifo <= 4'hF;
        settle();
        rdc("standby hold", `IRF_OFS_CNV, 8'h00);
        standby <= 1'b0;
        settle();
        rdc("standby off", `IRF_OFS_CNV, 8'h0F);
        standby <= 1'b1;
        w_fifo <= 4'h0;
        settle();
        rdc("standby keep", `IRF_OFS_CNV, 8'h0F);
        standby <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_periph();
        t_ports();
        t_level_edge();
        t_irq();
        t_standby();
        close_out();
    end
endmodule
`default_nettype wire
